// ==== include/lcx_pkg.sv ====
/*
 lcx_pkg: shared constants and event codes for the link control block.
 assumes a single 100 MHz system clock and synchronous reset.
*/
package lcx_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int PERSIST_MS = 100;
   localparam int PERSIST_CYC = PERSIST_MS * (CLK_HZ / 1000);
   localparam int BC_CNT_W = 5;
   localparam int EI_W = 6;
   localparam int EI_LOS = 0;
   localparam int EI_RAI = 1;
   localparam int EI_AIS = 2;
   localparam int EI_INT = 3;
   localparam int EI_CRC = 4;
   localparam int EI_EBIT = 5;
   localparam logic SA7_IDLE = 1'h1;
   localparam logic SA7_IDENT = 1'h0;

   // peer function elements
   typedef enum logic [3:0] {
      FE_IDREQ, FE_IDACK, FE_IDREL, FE_IDREJ,
      FE_UB_LE, FE_UB_AN, FE_BI_LE, FE_BI_AN,
      FE_BR_DEF, FE_BR_NDEF
   } lcx_fe_t;

   // management data units, both directions
   typedef enum logic [4:0] {
      M_AI, M_DI, M_IDREQ, M_IDACK, M_IDREL, M_IDREJ, M_IDOK, M_EIG,
      M_LUBR, M_LBR, M_LBRN, M_LBI, M_PROT, M_PROT_OK, M_PROT_FAIL,
      M_REL_SW, M_REHOME
   } lcx_mg_t;
endpackage

// ==== include/lcx_l1_if.sv ====
/*
 lcx_l1_if: primitives between link control and the layer 1 link fsm.
 assumes both ends run on the same clock; every signal is a pulse.
*/
interface lcx_l1_if import lcx_pkg::*; ();
   logic mph_id;
   logic mph_idr;
   logic mph_nor;
   logic mph_ai;
   logic mph_di;
   logic mph_idi;
   logic mph_eig;
   logic [EI_W-1:0] mph_ei;

   modport lc (
      output mph_id, mph_idr, mph_nor,
      input mph_ai, mph_di, mph_idi, mph_eig, mph_ei
   );
   modport l1 (
      input mph_id, mph_idr, mph_nor,
      output mph_ai, mph_di, mph_idi, mph_eig, mph_ei
   );
endinterface

// ==== rtl/lcx_bearer_cnt.sv ====
/*
 lcx_bearer_cnt: count of assigned on-demand bearer channels of one link.
 assumes assign and release pulses come from call control on ref_clk.
*/
module lcx_bearer_cnt import lcx_pkg::*; #(
   parameter int W = BC_CNT_W
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // channel events
   input wire logic bc_assign,
   input wire logic bc_release,
   // count
   output logic [W-1:0] count,
   output logic zero
);
   logic [W-1:0] cnt_d;

   always_comb begin
      cnt_d = count;
      if (bc_assign && !bc_release && count != '1) begin
         cnt_d = count + W'(1);
      end else if (bc_release && !bc_assign && count != '0) begin
         cnt_d = count - W'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         count <= '0;
         zero <= 1'h1;
      end else begin
         count <= cnt_d;
         zero <= (cnt_d == '0);
      end
   end
endmodule

// ==== rtl/lcx_l1_fsm.sv ====
/*
 lcx_l1_fsm: layer 1 link fsm with persistence timer and sa7 control.
 assumes framer events are one-cycle pulses on ref_clk.
*/
module lcx_l1_fsm import lcx_pkg::*; #(
   parameter int PERSIST = PERSIST_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // framer events
   input wire logic ev_norm1,
   input wire logic ev_norm0,
   input wire logic ev_los,
   input wire logic ev_rai,
   input wire logic ev_ais,
   input wire logic ev_int,
   input wire logic ev_int_gone,
   input wire logic crc_err,
   input wire logic ebit_err,
   // link control side
   lcx_l1_if.l1 l1,
   // line
   output logic tx_sa7
);
   typedef enum logic [2:0] {
      L_NORM, L_LOCF, L_REMF, L_INTF, L_IDS, L_IDR
   } lcx_l1_st_t;
   localparam int TW = $clog2(PERSIST + 1);

   lcx_l1_st_t st_q, st_d;
   logic [TW-1:0] tm_q, tm_d;
   logic run_q, run_d, ai_d, di_d, idi_d, eig_d, fail, quiet;
   logic [EI_W-1:0] ei_d;

   assign fail = st_q inside {L_LOCF, L_REMF, L_INTF};
   assign quiet = !(ev_norm1 || ev_norm0 || ev_los || ev_rai || ev_ais
                    || ev_int || ev_int_gone);

   always_comb begin
      st_d = st_q;
      run_d = run_q;
      tm_d = tm_q;
      ai_d = 1'h0;
      di_d = 1'h0;
      idi_d = 1'h0;
      eig_d = 1'h0;
      ei_d = '0;
      ei_d[EI_CRC] = crc_err;
      ei_d[EI_EBIT] = ebit_err;
      if (run_q) begin
         tm_d = tm_q - TW'(1);
         if (tm_q == '0) begin
            run_d = 1'h0;
            ai_d = st_q inside {L_NORM, L_IDR};
            di_d = st_q inside {L_LOCF, L_REMF};
         end
      end
      if (ev_int && st_q != L_INTF) begin
         di_d = 1'h1;
         ei_d[EI_INT] = 1'h1;
         st_d = L_INTF;
         run_d = 1'h0;
      end else if (st_q == L_INTF) begin
         ei_d[EI_LOS] = ev_los;
         ei_d[EI_AIS] = ev_ais;
         if (ev_int_gone) begin
            st_d = L_REMF;
         end
      end else if (ev_los || ev_ais) begin
         ei_d[EI_LOS] = ev_los;
         ei_d[EI_AIS] = ev_ais;
         st_d = L_LOCF;
         if (st_q != L_LOCF && st_q != L_REMF) begin
            run_d = 1'h1;
            tm_d = TW'(PERSIST - 1);
         end
      end else if (ev_rai && st_q != L_REMF) begin
         ei_d[EI_RAI] = 1'h1;
         st_d = L_REMF;
         run_d = 1'h1;
         tm_d = TW'(PERSIST - 1);
      end else if (ev_norm1 && st_q inside {L_LOCF, L_REMF, L_IDR}) begin
         st_d = L_NORM;
         run_d = (st_q != L_IDR);
         tm_d = TW'(PERSIST - 1);
      end else if (ev_norm0 && st_q inside {L_NORM, L_LOCF, L_REMF}) begin
         st_d = L_IDR;
         run_d = (st_q != L_NORM);
         tm_d = TW'(PERSIST - 1);
      end
      if (st_d == st_q) begin
         if (fail && (l1.mph_id || l1.mph_nor || l1.mph_idr)) begin
            di_d = 1'h1;
         end else if (l1.mph_id && st_q inside {L_NORM, L_IDR}) begin
            st_d = L_IDS;
         end else if (l1.mph_nor && st_q == L_IDS) begin
            st_d = L_NORM;
         end else if (l1.mph_idr && st_q == L_IDR) begin
            idi_d = 1'h1;
         end else if (l1.mph_idr && st_q == L_NORM) begin
            eig_d = 1'h1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_q <= L_LOCF;
         run_q <= 1'h0;
         tm_q <= '0;
         tx_sa7 <= SA7_IDLE;
         l1.mph_ai <= 1'h0;
         l1.mph_di <= 1'h0;
         l1.mph_idi <= 1'h0;
         l1.mph_eig <= 1'h0;
         l1.mph_ei <= '0;
      end else begin
         st_q <= st_d;
         run_q <= run_d;
         tm_q <= tm_d;
         tx_sa7 <= (st_d == L_IDS) ? SA7_IDENT : SA7_IDLE;
         l1.mph_ai <= ai_d;
         l1.mph_di <= di_d;
         l1.mph_idi <= idi_d;
         l1.mph_eig <= eig_d;
         l1.mph_ei <= ei_d;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   a_ident_sa7:
   assert property (l1.mph_id && st_q == L_NORM && quiet
      |=> tx_sa7 == SA7_IDENT ##1 tx_sa7 == SA7_IDENT || !$past(quiet)
          || $past(l1.mph_nor))
      else $error("sa7 not driven to zero on id");
   a_idr_answer:
   assert property (l1.mph_idr && st_q == L_IDR && quiet
      |=> l1.mph_idi && !l1.mph_eig)
      else $error("id request in received state not answered");
endmodule

// ==== rtl/lcx_link_ctrl.sv ====
/*
 lcx_link_ctrl: link control for one 2048 kbit/s link, either end.
 assumes peer, management and framer events are one-cycle pulses on ref_clk.
*/
module lcx_link_ctrl import lcx_pkg::*; #(
   parameter bit IS_LE = 1'h1,
   parameter int PERSIST = PERSIST_CYC,
   parameter int BC_W = BC_CNT_W
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // configuration
   input wire logic prim_sec,
   // peer function elements
   input wire logic fe_rx_vld,
   input wire lcx_fe_t fe_rx_code,
   output logic fe_rx_rdy,
   output logic fe_tx_vld,
   output lcx_fe_t fe_tx_code,
   // system management
   input wire logic mg_rx_vld,
   input wire lcx_mg_t mg_rx_code,
   output logic mg_rx_rdy,
   output logic mg_tx_vld,
   output lcx_mg_t mg_tx_code,
   output logic mdu_lubi,
   output logic mdu_lbi,
   output logic [EI_W-1:0] mdu_ei,
   // bearer channels
   input wire logic bc_assign,
   input wire logic bc_release,
   output logic bearer_dis,
   output logic [BC_W-1:0] bc_count,
   // framer
   input wire logic ev_norm1,
   input wire logic ev_norm0,
   input wire logic ev_los,
   input wire logic ev_rai,
   input wire logic ev_ais,
   input wire logic ev_int,
   input wire logic ev_int_gone,
   input wire logic crc_err,
   input wire logic ebit_err,
   output logic tx_sa7,
   // link status
   output logic link_oper,
   output logic test_ok,
   output logic intf_nonop
);
   typedef enum logic [3:0] {
      S_FAIL, S_FAIL_BLK, S_BLK, S_LOC_UB, S_REM_UB, S_OPER, S_REM_WAIT,
      S_REM_ID, S_LOC_ID, S_BREQ, S_DEF_WAIT, S_PROT_REQ, S_PROT, S_REHOME
   } lcx_lc_st_t;

   localparam lcx_fe_t MY_UB = IS_LE ? FE_UB_LE : FE_UB_AN;
   localparam lcx_fe_t PEER_UB = IS_LE ? FE_UB_AN : FE_UB_LE;
   localparam lcx_fe_t MY_BI = IS_LE ? FE_BI_LE : FE_BI_AN;
   localparam lcx_fe_t PEER_BI = IS_LE ? FE_BI_AN : FE_BI_LE;

   function automatic logic nonop_f(input lcx_lc_st_t s);
      return s inside {S_FAIL, S_FAIL_BLK, S_BLK, S_LOC_UB, S_REM_UB};
   endfunction

   lcx_l1_if l1 ();
   lcx_lc_st_t st_q, st_d;
   lcx_fe_t fe_c_d;
   lcx_mg_t mg_c_d;
   logic fe_v_d, mg_v_d, lubi_d, lbi_d, id_d, idr_d, nor_d, ai_q, ai_d;
   logic l1ev, bc_zero, quiet;

   lcx_l1_fsm #(.PERSIST(PERSIST)) u_l1 (
      .ref_clk(ref_clk),
      .srst(srst),
      .ev_norm1(ev_norm1),
      .ev_norm0(ev_norm0),
      .ev_los(ev_los),
      .ev_rai(ev_rai),
      .ev_ais(ev_ais),
      .ev_int(ev_int),
      .ev_int_gone(ev_int_gone),
      .crc_err(crc_err),
      .ebit_err(ebit_err),
      .l1(l1.l1),
      .tx_sa7(tx_sa7)
   );

   lcx_bearer_cnt #(.W(BC_W)) u_bc (
      .ref_clk(ref_clk),
      .srst(srst),
      .bc_assign(bc_assign),
      .bc_release(bc_release),
      .count(bc_count),
      .zero(bc_zero)
   );

   // one event per cycle: layer 1 first, then peer, then management
   assign l1ev = l1.mph_di || l1.mph_ai || l1.mph_idi || l1.mph_eig;
   assign fe_rx_rdy = !l1ev;
   assign mg_rx_rdy = !l1ev && !fe_rx_vld;
   assign quiet = !l1ev && !fe_rx_vld && !mg_rx_vld;

   always_comb begin
      st_d = st_q;
      fe_v_d = 1'h0;
      fe_c_d = fe_tx_code;
      mg_v_d = 1'h0;
      mg_c_d = mg_tx_code;
      lubi_d = 1'h0;
      lbi_d = 1'h0;
      id_d = 1'h0;
      idr_d = 1'h0;
      nor_d = 1'h0;
      ai_d = ai_q;
      if (l1.mph_di) begin
         ai_d = 1'h0;
         mg_v_d = 1'h1;
         mg_c_d = M_DI;
         if (nonop_f(st_q)) begin
            st_d = (st_q == S_FAIL) ? S_FAIL : S_FAIL_BLK;
         end else begin
            lbi_d = 1'h1;
            st_d = S_FAIL;
            if (!IS_LE && l1.mph_ei[EI_INT]) begin
               st_d = S_FAIL_BLK;
               fe_v_d = 1'h1;
               fe_c_d = FE_BI_AN;
               mg_c_d = M_PROT;
            end
         end
      end else if (l1.mph_ai) begin
         ai_d = 1'h1;
         mg_v_d = 1'h1;
         mg_c_d = M_AI;
         if (st_q == S_FAIL) begin
            st_d = S_OPER;
            lubi_d = 1'h1;
         end else if (st_q == S_FAIL_BLK) begin
            st_d = S_BLK;
            lbi_d = 1'h1;
         end
      end else if (l1.mph_idi || l1.mph_eig) begin
         if (st_q == S_LOC_ID) begin
            mg_v_d = 1'h1;
            mg_c_d = l1.mph_idi ? M_IDOK : M_EIG;
            fe_v_d = 1'h1;
            fe_c_d = FE_IDREL;
            st_d = S_OPER;
         end
      end else if (fe_rx_vld) begin
         case (fe_rx_code)
            FE_IDREQ: begin
               if (st_q == S_OPER || (st_q == S_LOC_ID && !IS_LE)) begin
                  mg_v_d = 1'h1;
                  mg_c_d = M_IDREQ;
                  st_d = S_REM_WAIT;
               end else begin
                  fe_v_d = 1'h1;
                  fe_c_d = FE_IDREJ;
               end
            end
            FE_IDACK: begin
               idr_d = (st_q == S_LOC_ID);
            end
            FE_IDREL: begin
               if (st_q == S_REM_ID) begin
                  nor_d = 1'h1;
                  mg_v_d = 1'h1;
                  mg_c_d = M_IDREL;
                  st_d = S_OPER;
               end
            end
            FE_IDREJ: begin
               if (st_q == S_LOC_ID) begin
                  mg_v_d = 1'h1;
                  mg_c_d = M_IDREJ;
                  st_d = S_OPER;
               end
            end
            default: begin
               if (fe_rx_code == PEER_UB && st_q == S_BLK) begin
                  st_d = S_REM_UB;
                  mg_v_d = 1'h1;
                  mg_c_d = M_LUBR;
               end else if (fe_rx_code == PEER_UB && st_q == S_LOC_UB) begin
                  st_d = S_OPER;
                  lubi_d = 1'h1;
               end else if (fe_rx_code == PEER_UB && st_q == S_BREQ) begin
                  st_d = S_OPER;
                  mg_v_d = 1'h1;
                  mg_c_d = M_LUBR;
               end else if (fe_rx_code == PEER_BI) begin
                  if (!nonop_f(st_q)) begin
                     lbi_d = 1'h1;
                     mg_v_d = 1'h1;
                     mg_c_d = M_LBI;
                  end
                  st_d = (st_q inside {S_FAIL, S_FAIL_BLK}) ? S_FAIL_BLK
                                                          : S_BLK;
               end else if (IS_LE && st_q == S_OPER
                            && fe_rx_code == FE_BR_DEF) begin
                  mg_v_d = 1'h1;
                  mg_c_d = M_LBR;
                  st_d = S_DEF_WAIT;
               end else if (IS_LE && st_q == S_OPER
                            && fe_rx_code == FE_BR_NDEF) begin
                  mg_v_d = 1'h1;
                  mg_c_d = M_LBRN;
                  st_d = S_PROT_REQ;
               end
            end
         endcase
      end else if (mg_rx_vld) begin
         case (mg_rx_code)
            M_IDREQ: begin
               if (st_q == S_OPER && ai_q) begin
                  fe_v_d = 1'h1;
                  fe_c_d = FE_IDREQ;
                  st_d = S_LOC_ID;
               end else begin
                  mg_v_d = 1'h1;
                  mg_c_d = M_IDREJ;
               end
            end
            M_IDACK: begin
               if (st_q == S_REM_WAIT) begin
                  id_d = 1'h1;
                  fe_v_d = 1'h1;
                  fe_c_d = FE_IDACK;
                  st_d = S_REM_ID;
               end
            end
            M_IDREJ: begin
               if (st_q == S_REM_WAIT) begin
                  fe_v_d = 1'h1;
                  fe_c_d = FE_IDREJ;
                  st_d = S_OPER;
               end
            end
            M_LUBR: begin
               if (st_q inside {S_BLK, S_REM_UB}) begin
                  fe_v_d = 1'h1;
                  fe_c_d = MY_UB;
                  st_d = (st_q == S_BLK) ? S_LOC_UB : S_OPER;
                  lubi_d = (st_q == S_REM_UB);
               end else if (st_q == S_FAIL) begin
                  st_d = S_FAIL_BLK;
               end
            end
            M_LBR, M_LBRN: begin
               if (!IS_LE && st_q == S_OPER) begin
                  fe_v_d = 1'h1;
                  fe_c_d = (mg_rx_code == M_LBR) ? FE_BR_DEF : FE_BR_NDEF;
                  st_d = S_BREQ;
               end else if (st_q == S_FAIL) begin
                  st_d = S_FAIL_BLK;
               end
            end
            M_LBI: begin
               if (!nonop_f(st_q) || st_q == S_FAIL) begin
                  fe_v_d = 1'h1;
                  fe_c_d = MY_BI;
                  lbi_d = !nonop_f(st_q);
                  st_d = (st_q == S_FAIL) ? S_FAIL_BLK : S_BLK;
               end
            end
            M_PROT_OK: begin
               if (st_q == S_PROT) begin
                  mg_v_d = 1'h1;
                  mg_c_d = M_REL_SW;
                  st_d = S_REHOME;
               end
            end
            M_PROT_FAIL: begin
               if (st_q == S_PROT) begin
                  fe_v_d = 1'h1;
                  fe_c_d = FE_UB_LE;
                  st_d = S_OPER;
               end
            end
            default: begin
            end
         endcase
      end else begin
         case (st_q)
            S_DEF_WAIT: begin
               if (bc_zero) begin
                  st_d = S_PROT_REQ;
               end
            end
            S_PROT_REQ: begin
               mg_v_d = 1'h1;
               mg_c_d = M_PROT;
               st_d = S_PROT;
            end
            S_REHOME: begin
               mg_v_d = 1'h1;
               mg_c_d = M_REHOME;
               fe_v_d = 1'h1;
               fe_c_d = FE_BI_LE;
               lbi_d = 1'h1;
               st_d = S_BLK;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_q <= S_FAIL;
         ai_q <= 1'h0;
         fe_tx_vld <= 1'h0;
         fe_tx_code <= FE_IDREQ;
         mg_tx_vld <= 1'h0;
         mg_tx_code <= M_AI;
         mdu_lubi <= 1'h0;
         mdu_lbi <= 1'h0;
         mdu_ei <= '0;
         l1.mph_id <= 1'h0;
         l1.mph_idr <= 1'h0;
         l1.mph_nor <= 1'h0;
         bearer_dis <= 1'h1;
         link_oper <= 1'h0;
         test_ok <= 1'h1;
         intf_nonop <= 1'h0;
      end else begin
         st_q <= st_d;
         ai_q <= ai_d;
         fe_tx_vld <= fe_v_d;
         fe_tx_code <= fe_c_d;
         mg_tx_vld <= mg_v_d;
         mg_tx_code <= mg_c_d;
         mdu_lubi <= lubi_d;
         mdu_lbi <= lbi_d;
         mdu_ei <= l1.mph_ei;
         l1.mph_id <= id_d;
         l1.mph_idr <= idr_d;
         l1.mph_nor <= nor_d;
         bearer_dis <= !(st_d inside {S_OPER, S_REM_WAIT, S_REM_ID,
                                      S_LOC_ID, S_BREQ});
         link_oper <= !nonop_f(st_d);
         test_ok <= nonop_f(st_d);
         intf_nonop <= prim_sec && nonop_f(st_d);
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence s_ndef_in;
      IS_LE && fe_rx_vld && fe_rx_rdy && fe_rx_code == FE_BR_NDEF
         && st_q == S_OPER;
   endsequence
   sequence s_idreq_busy;
      st_q == S_LOC_ID && fe_rx_vld && fe_rx_rdy && fe_rx_code == FE_IDREQ;
   endsequence

   a_ndef_order:
   assert property (s_ndef_in ##1 quiet
      |=> mg_tx_vld && mg_tx_code == M_PROT && st_q == S_PROT)
      else $error("non-deferred block did not request protection");
   a_prot_fail:
   assert property (st_q == S_PROT && mg_rx_vld && mg_rx_rdy
      && mg_rx_code == M_PROT_FAIL
      |=> fe_tx_vld && fe_tx_code == FE_UB_LE && st_q == S_OPER)
      else $error("protection failure not answered with unblock");
   a_defer_hold:
   assert property (st_q == S_DEF_WAIT && !bc_zero && quiet
      |=> st_q == S_DEF_WAIT && bearer_dis)
      else $error("deferred block left while bearers busy");
   a_defer_go:
   assert property (st_q == S_DEF_WAIT && bc_zero && quiet
      |=> st_q == S_PROT_REQ)
      else $error("deferred block stuck with no bearers");
   a_test_nonop:
   assert property (test_ok == nonop_f(st_q) && link_oper == !test_ok)
      else $error("test permission disagrees with link state");
   a_id_busy:
   assert property ((s_idreq_busy and IS_LE)
      |=> fe_tx_vld && fe_tx_code == FE_IDREJ && st_q == S_LOC_ID)
      else $error("identification accepted while busy");
   a_an_yield:
   assert property ((s_idreq_busy and !IS_LE)
      |=> mg_tx_vld && mg_tx_code == M_IDREQ && st_q == S_REM_WAIT)
      else $error("access side did not yield identification");
   a_id_needs_ai:
   assert property (fe_tx_vld && fe_tx_code == FE_IDREQ
      |-> $past(ai_q) && $past(st_q) == S_OPER)
      else $error("identification started without layer 1 up");
   a_lubi_entry:
   assert property (st_q == S_OPER && nonop_f($past(st_q)) |-> mdu_lubi)
      else $error("entry to operational not reported");
endmodule

// ==== testbench/lcx_peer.sv ====
/*
 lcx_peer: peer link control entity at the access end.
 assumes it shares ref_clk with the block; sends on command only.
*/
module lcx_peer import lcx_pkg::*; (
   // clock
   input wire logic ref_clk,
   // toward the block
   output logic fe_vld,
   output lcx_fe_t fe_code,
   input wire logic fe_rdy,
   // from the block
   input wire logic rx_vld,
   input wire lcx_fe_t rx_code
);
   timeunit 1ns;
   timeprecision 1ns;
   lcx_fe_t got_q[$];
   logic stuck = 1'h0;
   initial begin
      fe_vld = 1'h0;
      fe_code = FE_IDREQ;
   end
   // log of elements from the block
   always @(posedge ref_clk) begin
      if (rx_vld)
         got_q.push_back(rx_code);
   end
   // one element, held until taken or for at most nine cycles, code scrambled on release
   task automatic send(input lcx_fe_t c);
      @(posedge ref_clk);
      fe_vld <= 1'h1;
      fe_code <= c;
      @(negedge ref_clk);
      for (int i = 0; i < 8 && !fe_rdy; i++)
         @(negedge ref_clk);
      stuck = !fe_rdy;
      @(posedge ref_clk);
      fe_vld <= 1'h0;
      fe_code <= lcx_fe_t'(~c);
   endtask
endmodule

// ==== testbench/tb.sv ====
/*
 tb: self-checking bench for the exchange-end link control.
 assumes lcx_pkg and lcx_peer are compiled first.
*/
module tb import lcx_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, srst = 1'h1, prim_sec = 1'h1;
   logic fe_rx_vld, fe_rx_rdy, fe_tx_vld, mg_rx_rdy, mg_tx_vld;
   lcx_fe_t fe_rx_code, fe_tx_code;
   logic mg_rx_vld = 1'h0;
   lcx_mg_t mg_rx_code = M_AI;
   lcx_mg_t mg_tx_code;
   lcx_mg_t mg_q[$];
   logic mdu_lubi, mdu_lbi, bearer_dis, tx_sa7, link_oper, test_ok;
   logic intf_nonop, bc_assign = 1'h0, bc_release = 1'h0;
   logic ev_norm1 = 1'h0, ev_norm0 = 1'h0, ev_los = 1'h0, ev_rai = 1'h0;
   logic ev_ais = 1'h0, ev_int = 1'h0, ev_int_gone = 1'h0;
   logic crc_err = 1'h0, ebit_err = 1'h0;
   logic [7:0] lubi_n = 8'h0, lbi_n = 8'h0, fails = 8'h0;
   logic [7:0] checks_done = 8'h0;
   logic [BC_CNT_W-1:0] bc_count;
   logic [EI_W-1:0] mdu_ei;
   lcx_link_ctrl #(.IS_LE(1'h1), .PERSIST(8)) u_dut (.ref_clk, .srst,
      .prim_sec, .fe_rx_vld, .fe_rx_code, .fe_rx_rdy, .fe_tx_vld,
      .fe_tx_code, .mg_rx_vld, .mg_rx_code, .mg_rx_rdy, .mg_tx_vld,
      .mg_tx_code, .mdu_lubi, .mdu_lbi, .mdu_ei, .bc_assign, .bc_release,
      .bearer_dis, .bc_count, .ev_norm1, .ev_norm0, .ev_los, .ev_rai,
      .ev_ais, .ev_int, .ev_int_gone, .crc_err, .ebit_err, .tx_sa7,
      .link_oper, .test_ok, .intf_nonop);
   lcx_peer u_peer (.ref_clk, .fe_vld(fe_rx_vld), .fe_code(fe_rx_code),
      .fe_rdy(fe_rx_rdy), .rx_vld(fe_tx_vld), .rx_code(fe_tx_code));
   initial begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (!srst) begin
         if (mg_tx_vld)
            mg_q.push_back(mg_tx_code);
         lubi_n <= lubi_n + 8'(mdu_lubi);
         lbi_n <= lbi_n + 8'(mdu_lbi);
      end
   end
   task automatic report_and_stop;
      if (fails == 8'h0 && checks_done != 8'h0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic mg(input lcx_mg_t c);
      @(posedge ref_clk);
      mg_rx_vld <= 1'h1;
      mg_rx_code <= c;
      @(negedge ref_clk);
      for (int i = 0; i < 8 && !mg_rx_rdy; i++)
         @(negedge ref_clk);
      if (!mg_rx_rdy) begin
         fails++;
         report_and_stop();
      end else begin
         @(posedge ref_clk);
         mg_rx_vld <= 1'h0;
      end
   endtask
   task automatic pf(input lcx_fe_t c);
      u_peer.send(c);
      if (u_peer.stuck) begin
         fails++;
         report_and_stop();
      end
   endtask
   task automatic exp_mg(input lcx_mg_t c);
      for (int i = 0; i < 200 && mg_q.size() == 0; i++)
         @(negedge ref_clk);
      if (mg_q.size() == 0) begin
         fails++;
         report_and_stop();
      end else begin
         chk(8'(mg_q.pop_front()), 8'(c));
      end
   endtask
   task automatic exp_fe(input lcx_fe_t c);
      for (int i = 0; i < 200 && u_peer.got_q.size() == 0; i++)
         @(negedge ref_clk);
      if (u_peer.got_q.size() == 0) begin
         fails++;
         report_and_stop();
      end else begin
         chk(8'(u_peer.got_q.pop_front()), 8'(c));
      end
   endtask
   task automatic t_up;
      mg(M_IDREQ);
      exp_mg(M_IDREJ);
      @(posedge ref_clk);
      ev_norm1 <= 1'h1;
      @(posedge ref_clk);
      ev_norm1 <= 1'h0;
      exp_mg(M_AI);
      @(negedge ref_clk);
      chk(lubi_n, 8'h1);
      chk(8'(test_ok), 8'h0);
      @(posedge ref_clk);
      crc_err <= 1'h1;
      @(posedge ref_clk);
      crc_err <= 1'h0;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(8'(mdu_ei), 8'h10);
   endtask
   task automatic t_ident;
      pf(FE_IDREQ);
      exp_mg(M_IDREQ);
      mg(M_IDACK);
      exp_fe(FE_IDACK);
      @(negedge ref_clk);
      chk(8'(tx_sa7), 8'(SA7_IDENT));
      pf(FE_IDREL);
      exp_mg(M_IDREL);
      @(negedge ref_clk);
      chk(8'(tx_sa7), 8'(SA7_IDLE));
   endtask
   task automatic t_local;
      mg(M_IDREQ);
      exp_fe(FE_IDREQ);
      pf(FE_IDREQ);
      exp_fe(FE_IDREJ);
      pf(FE_IDACK);
      exp_mg(M_EIG);
      exp_fe(FE_IDREL);
   endtask
   task automatic t_refuse(input lcx_fe_t f, input lcx_mg_t m);
      if (m == M_LBR) begin
         @(posedge ref_clk);
         bc_assign <= 1'h1;
         @(posedge ref_clk);
         bc_assign <= 1'h0;
      end
      pf(f);
      exp_mg(m);
      if (m == M_LBR) begin
         chk(8'(bearer_dis), 8'h1);
         chk(8'(bc_count), 8'h1);
         repeat (20) @(negedge ref_clk);
         chk(8'(mg_q.size()), 8'h0);
         @(posedge ref_clk);
         bc_release <= 1'h1;
         @(posedge ref_clk);
         bc_release <= 1'h0;
      end
      exp_mg(M_PROT);
      mg(M_PROT_FAIL);
      exp_fe(FE_UB_LE);
   endtask
   task automatic t_force;
      pf(FE_BI_AN);
      exp_mg(M_LBI);
      mg(M_LUBR);
      exp_fe(FE_UB_LE);
      pf(FE_UB_AN);
      @(negedge ref_clk);
      @(negedge ref_clk);
      chk(lbi_n, 8'h1);
      chk(lubi_n, 8'h2);
   endtask
   task automatic t_block;
      pf(FE_BR_NDEF);
      exp_mg(M_LBRN);
      exp_mg(M_PROT);
      mg(M_PROT_OK);
      exp_mg(M_REL_SW);
      exp_mg(M_REHOME);
      exp_fe(FE_BI_LE);
      @(negedge ref_clk);
      chk(lbi_n, 8'h2);
      chk(8'(test_ok), 8'h1);
      chk(8'(intf_nonop), 8'h1);
      @(posedge ref_clk);
      prim_sec <= 1'h0;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(8'(intf_nonop), 8'h0);
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      srst <= 1'h0;
      t_up();
      t_ident();
      t_local();
      t_refuse(FE_BR_DEF, M_LBR);
      t_refuse(FE_BR_NDEF, M_LBRN);
      t_force();
      t_block();
      report_and_stop();
   end
endmodule
